// *** logic/amd_pkg.sv ***
// Purpose: Shared types and constants of the address mode decoder.
// Assumes: Opcode mode comes from an external opcode attribute table; the page comes from the $18 prefix.
// Notes:   The shared opcode, postbyte and mode encodings live here; the state encoding stays in amd_decoder.
//
// Contract
// - Words are big-endian: high byte first.
// - Any byte address accepted, no alignment.
// - Literal operand taken from stream, 8/16 bits.
// - Page-zero address: one byte, high byte zero.
// - Full address mode carries 16-bit address.
// - Relative target is program counter plus offset.
// - Indexed: postbyte then zero to two extensions.
// - Base select: X, Y, stack pointer, counter.
// - Short form adds 5-bit signed constant.
// - Wide constant form: 9 or 16 bit offset.
// - Nine-bit offset low byte from one extension.
// - Sixteen-bit offset from two extensions, added.
// - Sixteen-bit offset indirect: sum addresses pointer.
// - Auto adjust pre or post, -8..-1, +1..+8.
// - Auto adjust never uses program counter base.
// - Accumulator offset A, B or D, unsigned.
// - Selector 11: base plus D addresses pointer.
// - Prefix $18 selects second opcode page.
// - D is A high byte, B low byte.

`default_nettype none

package amd_pkg;

	// ----------------------------------------------------------------
	// Opcode and postbyte encodings
	// ----------------------------------------------------------------
	localparam logic [7:0] PAGE2_PREFIX   = 8'h18;
	localparam logic [2:0] WIDE_PREFIX    = 3'h7;
	localparam logic [1:0] BASE_X         = 2'h0;
	localparam logic [1:0] BASE_Y         = 2'h1;
	localparam logic [1:0] BASE_SP        = 2'h2;
	localparam logic [1:0] BASE_PC        = 2'h3;
	localparam logic [1:0] ACC_A          = 2'h0;
	localparam logic [1:0] ACC_B          = 2'h1;
	localparam logic [1:0] ACC_D          = 2'h2;
	localparam logic [1:0] ACC_D_INDIRECT = 2'h3;
	localparam int         SHORT_BIT      = 5;
	localparam int         AUTO_POST_BIT  = 4;
	localparam int         WIDE_ACC_BIT   = 2;
	localparam int         WIDE_SIZE_BIT  = 1;
	localparam int         WIDE_SIGN_BIT  = 0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		REGISTER_ONLY_MODE,
		LITERAL8_OPERAND_MODE,
		LITERAL16_OPERAND_MODE,
		PAGE_ZERO_MODE,
		FULL_ADDRESS_MODE,
		RELATIVE8_MODE,
		RELATIVE16_MODE,
		INDEXED_MODE
	} amd_mode_t;

	typedef enum logic [2:0] {
		INDEXED_SHORT_MODE,
		INDEXED_AUTO_MODE,
		INDEXED_NINE_BIT_MODE,
		INDEXED_SIXTEEN_BIT_MODE,
		INDEXED_SIXTEEN_INDIRECT_MODE,
		INDEXED_ACCUMULATOR_MODE,
		INDEXED_D_INDIRECT_MODE
	} amd_form_t;

	typedef struct packed {
		amd_form_t   form;
		logic [1:0]  base_register_select;
		logic [1:0]  ext_count;
		logic [15:0] const_offset;
		logic        post_adjust;
		logic        nine_bit_sign;
		logic [1:0]  accumulator_offset_select;
	} amd_idx_t;

	typedef struct packed {
		logic [7:0]  acc_a;
		logic [7:0]  acc_b;
		logic [15:0] index_x;
		logic [15:0] index_y;
		logic [15:0] stack_pointer;
	} amd_regs_t;

	typedef struct packed {
		amd_mode_t   mode;
		amd_form_t   form;
		logic        page2;
		logic [7:0]  opcode;
		logic [15:0] address;
		logic [15:0] literal;
		logic        indirect;
		logic        wb_en;
		logic [1:0]  wb_sel;
		logic [15:0] wb_value;
		logic [15:0] next_pc;
	} amd_result_t;

endpackage

`default_nettype wire

// *** logic/amd_postbyte.sv ***
// Purpose: Combinational split of an index postbyte into its fields.
// Assumes: The postbyte is stable while the caller samples the result.
// Notes:   Pure decode; the caller adds bases and extension bytes.

`timescale 1ns/10ps
`default_nettype none

module amd_postbyte (
	// Postbyte in
	input  wire logic [7:0]   index_postbyte_i,
	// Decoded fields out
	output amd_pkg::amd_idx_t fields_o
);

	logic [3:0] adj_n;

	assign adj_n = index_postbyte_i[3:0];

	always_comb begin
		fields_o                           = '0;
		fields_o.base_register_select      = index_postbyte_i[7:6];
		fields_o.accumulator_offset_select = index_postbyte_i[1:0];
		fields_o.nine_bit_sign             = index_postbyte_i[amd_pkg::WIDE_SIGN_BIT];
		fields_o.form                      = amd_pkg::INDEXED_SHORT_MODE;
		if (!index_postbyte_i[amd_pkg::SHORT_BIT]) begin
			fields_o.const_offset = {{11{index_postbyte_i[4]}}, index_postbyte_i[4:0]};
		end else if (index_postbyte_i[7:5] == amd_pkg::WIDE_PREFIX) begin
			fields_o.base_register_select = index_postbyte_i[4:3];
			if (!index_postbyte_i[amd_pkg::WIDE_ACC_BIT]) begin
				if (!index_postbyte_i[amd_pkg::WIDE_SIZE_BIT]) begin
					fields_o.form      = amd_pkg::INDEXED_NINE_BIT_MODE;
					fields_o.ext_count = 2'h1;
				end else if (!index_postbyte_i[amd_pkg::WIDE_SIGN_BIT]) begin
					fields_o.form      = amd_pkg::INDEXED_SIXTEEN_BIT_MODE;
					fields_o.ext_count = 2'h2;
				end else begin
					fields_o.form      = amd_pkg::INDEXED_SIXTEEN_INDIRECT_MODE;
					fields_o.ext_count = 2'h2;
				end
			end else if (index_postbyte_i[1:0] == amd_pkg::ACC_D_INDIRECT) begin
				fields_o.form = amd_pkg::INDEXED_D_INDIRECT_MODE;
			end else begin
				fields_o.form = amd_pkg::INDEXED_ACCUMULATOR_MODE;
			end
		end else begin
			// A base field of 11 with bit 5 set always lands in the wide group above,
			// so the counter can never be an auto adjust base.
			fields_o.form        = amd_pkg::INDEXED_AUTO_MODE;
			fields_o.post_adjust = index_postbyte_i[amd_pkg::AUTO_POST_BIT];
			if (adj_n[3]) begin
				fields_o.const_offset = {12'hFFF, adj_n};
			end else begin
				fields_o.const_offset = {12'h000, adj_n} + 16'h0001;
			end
		end
	end

endmodule // amd_postbyte

`default_nettype wire

// *** logic/amd_decoder.sv ***
// Purpose: Walks the instruction byte stream and forms operand addresses.
// Assumes: Bytes arrive in program order; the attribute table answers in the same cycle.
// Notes:   One instruction at a time; the result is a one-cycle pulse.

`timescale 1ns/10ps
`default_nettype none

module amd_decoder (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_n_i,
	// Instruction fetch queue
	input  wire logic                 fq_valid_i,
	input  wire logic [7:0]           fq_byte_i,
	input  wire logic [15:0]          insn_pc_i,
	output logic                      fq_ready_o,
	// Opcode attribute lookup
	output logic [7:0]                attr_opcode_o,
	output logic                      attr_page2_o,
	output logic                      attr_query_o,
	input  wire amd_pkg::amd_mode_t   attr_mode_i,
	// Register file view
	input  wire amd_pkg::amd_regs_t   regs_i,
	// Memory operand bus, pointer reads
	output logic                      mem_req_o,
	output logic [15:0]               mem_addr_o,
	input  wire logic                 mem_ack_i,
	input  wire logic [7:0]           mem_data_i,
	// Decode result
	output logic                      res_valid_o,
	output amd_pkg::amd_result_t      res_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OPCODE,
		ST_LOOKUP,
		ST_POST,
		ST_EXT,
		ST_CALC,
		ST_PTR_HI,
		ST_PTR_LO
	} amd_state_t;

	amd_state_t          state;
	amd_state_t          next_state;
	logic                page2;
	logic [7:0]          opcode;
	amd_pkg::amd_mode_t  mode;
	logic [7:0]          index_postbyte;
	logic [15:0]         full_address_mode;
	logic [1:0]          ext_left;
	logic [15:0]         pc_cnt;
	logic [7:0]          ptr_hi;
	logic                take;
	amd_pkg::amd_idx_t   idx;
	logic [15:0]         base;
	logic [15:0]         offset;
	logic [15:0]         sum;
	logic                indirect;
	amd_pkg::amd_result_t next_res;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] pick_base(input logic [1:0] sel, input amd_pkg::amd_regs_t r,
	                                          input logic [15:0] pc);
		unique case (sel)
			amd_pkg::BASE_X:  pick_base = r.index_x;
			amd_pkg::BASE_Y:  pick_base = r.index_y;
			amd_pkg::BASE_SP: pick_base = r.stack_pointer;
			amd_pkg::BASE_PC: pick_base = pc;
		endcase
	endfunction

	function automatic logic [1:0] ext_for_mode(input amd_pkg::amd_mode_t m);
		unique case (m)
			amd_pkg::LITERAL8_OPERAND_MODE,
			amd_pkg::PAGE_ZERO_MODE,
			amd_pkg::RELATIVE8_MODE:         ext_for_mode = 2'h1;
			amd_pkg::LITERAL16_OPERAND_MODE,
			amd_pkg::FULL_ADDRESS_MODE,
			amd_pkg::RELATIVE16_MODE:        ext_for_mode = 2'h2;
			amd_pkg::REGISTER_ONLY_MODE,
			amd_pkg::INDEXED_MODE:           ext_for_mode = 2'h0;
		endcase
	endfunction

	amd_postbyte u_postbyte (
		.index_postbyte_i (index_postbyte),
		.fields_o         (idx)
	);

	// ----------------------------------------------------------------
	// Handshakes
	// ----------------------------------------------------------------
	// Bytes are taken only in the states that consume stream bytes; there is no
	// alignment check anywhere, any address is as good as another.
	// An indexed form without extension bytes passes through the extension state with
	// nothing left to take; refusing there keeps the next opcode from being swallowed.
	assign fq_ready_o   = (state == ST_OPCODE) || (state == ST_POST) || (state == ST_EXT && ext_left != 2'h0);
	assign take         = fq_ready_o && fq_valid_i;
	assign attr_opcode_o = opcode;
	assign attr_page2_o = page2;
	assign attr_query_o = (state == ST_LOOKUP);
	assign mem_req_o    = (state == ST_PTR_HI) || (state == ST_PTR_LO);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			ST_OPCODE: begin
				if (take && !(fq_byte_i == amd_pkg::PAGE2_PREFIX && !page2)) begin
					next_state = ST_LOOKUP;
				end
			end
			ST_LOOKUP: begin
				if (attr_mode_i == amd_pkg::INDEXED_MODE) begin
					next_state = ST_POST;
				end else if (attr_mode_i == amd_pkg::REGISTER_ONLY_MODE) begin
					next_state = ST_CALC;
				end else begin
					next_state = ST_EXT;
				end
			end
			ST_POST: begin
				if (take) begin
					next_state = ST_EXT;
				end
			end
			ST_EXT: begin
				if (ext_left == 2'h0) begin
					next_state = ST_CALC;
				end else if (take && ext_left == 2'h1) begin
					next_state = ST_CALC;
				end
			end
			ST_CALC: begin
				next_state = indirect ? ST_PTR_HI : ST_OPCODE;
			end
			ST_PTR_HI: begin
				if (mem_ack_i) begin
					next_state = ST_PTR_LO;
				end
			end
			ST_PTR_LO: begin
				if (mem_ack_i) begin
					next_state = ST_OPCODE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state <= ST_OPCODE;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Opcode and page capture
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			page2  <= 1'b0;
			opcode <= 8'h00;
			mode   <= amd_pkg::REGISTER_ONLY_MODE;
		end else begin
			if (state == ST_OPCODE && take) begin
				if (fq_byte_i == amd_pkg::PAGE2_PREFIX && !page2) begin
					page2 <= 1'b1;
				end else begin
					opcode <= fq_byte_i;
				end
			end
			if (state == ST_LOOKUP) begin
				mode <= attr_mode_i;
			end
			if (state == ST_CALC && !indirect) begin
				page2 <= 1'b0;
			end
			if (state == ST_PTR_LO && mem_ack_i) begin
				page2 <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Postbyte and extension bytes
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			index_postbyte <= 8'h00;
			full_address_mode            <= 16'h0000;
			ext_left       <= 2'h0;
		end else begin
			if (state == ST_LOOKUP) begin
				full_address_mode      <= 16'h0000;
				ext_left <= ext_for_mode(attr_mode_i);
			end
			if (state == ST_POST && take) begin
				index_postbyte <= fq_byte_i;
			end
			// The decoder sees the new postbyte one cycle later, so the count is
			// loaded here from the byte itself through a second decode.
			if (state == ST_POST && take) begin
				ext_left <= post_ext_count(fq_byte_i);
			end
			if (state == ST_EXT && take && ext_left != 2'h0) begin
				full_address_mode      <= {full_address_mode[7:0], fq_byte_i};
				ext_left <= ext_left - 2'h1;
			end
		end
	end

	function automatic logic [1:0] post_ext_count(input logic [7:0] pb);
		if (pb[7:5] == amd_pkg::WIDE_PREFIX && !pb[amd_pkg::WIDE_ACC_BIT]) begin
			post_ext_count = pb[amd_pkg::WIDE_SIZE_BIT] ? 2'h2 : 2'h1;
		end else begin
			post_ext_count = 2'h0;
		end
	endfunction

	// ----------------------------------------------------------------
	// Program counter tracking
	// ----------------------------------------------------------------
	// The counter follows every byte taken, so at the end it holds the address
	// of the next instruction, which is the reference for counter-relative sums.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pc_cnt <= 16'h0000;
		end else if (take) begin
			if (state == ST_OPCODE && !page2) begin
				pc_cnt <= insn_pc_i + 16'h0001;
			end else begin
				pc_cnt <= pc_cnt + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Address arithmetic
	// ----------------------------------------------------------------
	assign base = pick_base(idx.base_register_select, regs_i, pc_cnt);

	always_comb begin
		offset   = idx.const_offset;
		indirect = 1'b0;
		unique case (idx.form)
			amd_pkg::INDEXED_SHORT_MODE,
			amd_pkg::INDEXED_AUTO_MODE: begin
				offset = idx.const_offset;
			end
			amd_pkg::INDEXED_NINE_BIT_MODE: begin
				offset = {{8{idx.nine_bit_sign}}, full_address_mode[7:0]};
			end
			amd_pkg::INDEXED_SIXTEEN_BIT_MODE: begin
				offset = full_address_mode;
			end
			amd_pkg::INDEXED_SIXTEEN_INDIRECT_MODE: begin
				offset   = full_address_mode;
				indirect = (mode == amd_pkg::INDEXED_MODE);
			end
			amd_pkg::INDEXED_ACCUMULATOR_MODE: begin
				unique case (idx.accumulator_offset_select)
					amd_pkg::ACC_A: offset = {8'h00, regs_i.acc_a};
					amd_pkg::ACC_B: offset = {8'h00, regs_i.acc_b};
					default:        offset = {regs_i.acc_a, regs_i.acc_b};
				endcase
			end
			amd_pkg::INDEXED_D_INDIRECT_MODE: begin
				offset   = {regs_i.acc_a, regs_i.acc_b};
				indirect = (mode == amd_pkg::INDEXED_MODE);
			end
		endcase
	end

	assign sum = base + offset;

	always_comb begin
		next_res          = '0;
		next_res.mode     = mode;
		next_res.form     = idx.form;
		next_res.page2    = page2;
		next_res.opcode   = opcode;
		next_res.next_pc  = pc_cnt;
		unique case (mode)
			amd_pkg::REGISTER_ONLY_MODE: begin
				next_res.address = 16'h0000;
			end
			amd_pkg::LITERAL8_OPERAND_MODE: begin
				next_res.literal = {8'h00, full_address_mode[7:0]};
			end
			amd_pkg::LITERAL16_OPERAND_MODE: begin
				next_res.literal = full_address_mode;
			end
			amd_pkg::PAGE_ZERO_MODE: begin
				next_res.address = {8'h00, full_address_mode[7:0]};
			end
			amd_pkg::FULL_ADDRESS_MODE: begin
				next_res.address = full_address_mode;
			end
			amd_pkg::RELATIVE8_MODE: begin
				next_res.address = pc_cnt + {{8{full_address_mode[7]}}, full_address_mode[7:0]};
			end
			amd_pkg::RELATIVE16_MODE: begin
				next_res.address = pc_cnt + full_address_mode;
			end
			amd_pkg::INDEXED_MODE: begin
				next_res.indirect = indirect;
				if (idx.form == amd_pkg::INDEXED_AUTO_MODE) begin
					next_res.address  = idx.post_adjust ? base : sum;
					next_res.wb_en    = 1'b1;
					next_res.wb_sel   = idx.base_register_select;
					next_res.wb_value = sum;
				end else begin
					next_res.address = sum;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Pointer fetch and result
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			mem_addr_o  <= 16'h0000;
			ptr_hi      <= 8'h00;
			res_o       <= '0;
			res_valid_o <= 1'b0;
		end else begin
			res_valid_o <= 1'b0;
			if (state == ST_CALC) begin
				res_o <= next_res;
				if (indirect) begin
					mem_addr_o <= sum;
				end else begin
					res_valid_o <= 1'b1;
				end
			end
			if (state == ST_PTR_HI && mem_ack_i) begin
				ptr_hi     <= mem_data_i;
				mem_addr_o <= mem_addr_o + 16'h0001;
			end
			if (state == ST_PTR_LO && mem_ack_i) begin
				res_o.address <= {ptr_hi, mem_data_i};
				res_valid_o   <= 1'b1;
			end
		end
	end

endmodule // amd_decoder

`default_nettype wire

// *** testbench/amd_decoder_sva.sv ***
// Purpose: Port-level assertions for the address mode decoder.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   Bound to every decoder instance below.
`timescale 1ns/10ps
`default_nettype none

module amd_decoder_sva (
	// Clock and reset
	input wire logic                 clk_i,
	input wire logic                 rst_n_i,
	// Watched ports
	input wire logic                 fq_valid_i,
	input wire logic [7:0]           fq_byte_i,
	input wire logic                 fq_ready_o,
	input wire logic [7:0]           attr_opcode_o,
	input wire logic                 attr_page2_o,
	input wire logic                 attr_query_o,
	input wire logic                 mem_req_o,
	input wire logic [15:0]          mem_addr_o,
	input wire logic                 mem_ack_i,
	input wire logic [7:0]           mem_data_i,
	input wire logic                 res_valid_o,
	input wire amd_pkg::amd_result_t res_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	logic [7:0]  last_byte;
	logic [7:0]  ptr_hi;
	logic        ack_seen;
	logic [15:0] adj;
	logic        idx_res;
	logic        op_pos;
	logic        page_seen;
	logic        eff_page;
	logic        is_prefix;

	assign eff_page  = page_seen && !res_valid_o;
	assign is_prefix = fq_byte_i == amd_pkg::PAGE2_PREFIX && !eff_page;

	// Tracks whether the next byte taken opens an instruction; a result ends one.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			op_pos    <= 1'b1;
			page_seen <= 1'b0;
		end else if (fq_valid_i && fq_ready_o && (op_pos || res_valid_o)) begin
			op_pos    <= is_prefix;
			page_seen <= is_prefix || eff_page;
		end else if (res_valid_o) begin
			op_pos    <= 1'b1;
			page_seen <= 1'b0;
		end
	end

	assign adj = res_o.wb_value - res_o.address;
	assign idx_res = res_valid_o && res_o.mode == amd_pkg::INDEXED_MODE;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			last_byte <= 8'h00;
		else if (fq_valid_i && fq_ready_o)
			last_byte <= fq_byte_i;
	end

	// The flag tells the first pointer byte from the second one.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !mem_req_o)
			ack_seen <= 1'b0;
		else if (mem_ack_i)
			ack_seen <= !ack_seen;
	end

	always_ff @(posedge clk_i) begin
		if (mem_req_o && mem_ack_i && !ack_seen)
			ptr_hi <= mem_data_i;
	end

	AST_QUERY_PULSE: assert property (attr_query_o |-> !fq_ready_o ##1 !attr_query_o)
		else $error("lookup strobe longer than one cycle");
	AST_QUERY_OPCODE: assert property (attr_query_o |-> attr_opcode_o == last_byte)
		else $error("lookup opcode differs from last byte taken");
	AST_QUERY_PAGE: assert property (attr_query_o |-> attr_page2_o == page_seen)
		else $error("lookup page flag differs from prefix seen");
	AST_RES_PULSE: assert property (res_valid_o |=> !res_valid_o)
		else $error("result strobe longer than one cycle");
	AST_PTR_HOLD: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
		else $error("pointer request changed before ack");
	AST_PTR_STEP: assert property (mem_req_o && mem_ack_i && !ack_seen
		|=> mem_req_o && mem_addr_o == $past(mem_addr_o) + 16'h0001)
		else $error("second pointer byte not at next address");
	AST_PTR_RESULT: assert property (mem_req_o && mem_ack_i && ack_seen
		|=> res_valid_o && !mem_req_o && res_o.indirect && res_o.address == {ptr_hi, $past(mem_data_i)})
		else $error("pointer not assembled high byte first");
	AST_PAGE_ZERO: assert property (res_valid_o && res_o.mode == amd_pkg::PAGE_ZERO_MODE
		|-> res_o.address[15:8] == 8'h00)
		else $error("page zero address has nonzero high byte");
	AST_AUTO_NO_PC: assert property (idx_res && res_o.wb_en
		|-> res_o.wb_sel != amd_pkg::BASE_PC && res_o.form == amd_pkg::INDEXED_AUTO_MODE)
		else $error("write-back outside auto adjust or on counter");
	AST_AUTO_RANGE: assert property (idx_res && res_o.form == amd_pkg::INDEXED_AUTO_MODE
		|-> res_o.wb_en && (adj == 16'h0000 || adj inside {[16'h0001:16'h0008], [16'hFFF8:16'hFFFF]}))
		else $error("auto adjust step out of range");

	cover property (res_valid_o && res_o.indirect);
	cover property (res_valid_o && res_o.page2);
	cover property (idx_res && res_o.wb_en);
endmodule // amd_decoder_sva

bind amd_decoder amd_decoder_sva amd_decoder_sva_u (
	.clk_i, .rst_n_i, .fq_valid_i, .fq_byte_i, .fq_ready_o, .attr_opcode_o, .attr_page2_o, .attr_query_o,
	.mem_req_o, .mem_addr_o, .mem_ack_i, .mem_data_i, .res_valid_o, .res_o
);

`default_nettype wire

// *** testbench/amd_partner.sv ***
// Purpose: Opcode attribute table and memory responder for the decoder.
// Assumes: Memory answers change on the falling edge only; the attribute answer follows the opcode at once.
// Notes:   Memory byte at address a is a[7:0] xor A5.
`timescale 1ns/10ps
`default_nettype none

module amd_partner (
	// Clock
	input  wire logic         clk_i,
	// Attribute lookup
	input  wire logic [7:0]   attr_opcode_i,
	output amd_pkg::amd_mode_t attr_mode_o,
	// Memory operand bus
	input  wire logic [3:0]   delay_i,
	input  wire logic         mem_req_i,
	input  wire logic [15:0]  mem_addr_i,
	output logic              mem_ack_o,
	output logic [7:0]        mem_data_o
);
	logic [3:0] wait_cnt;

	// The low three opcode bits name the mode, so the bench picks a mode by its opcode.
	assign attr_mode_o = amd_pkg::amd_mode_t'(attr_opcode_i[2:0]);

	// Outside an ack the data flips every cycle, so a stale byte never passes for a fresh one.
	always @(negedge clk_i) begin
		if (mem_req_i && !mem_ack_o && wait_cnt >= delay_i) begin
			mem_ack_o <= 1'b1;
			mem_data_o <= mem_addr_i[7:0] ^ 8'hA5;
			wait_cnt <= 4'h0;
		end else begin
			mem_ack_o <= 1'b0;
			mem_data_o <= ~mem_data_o;
			wait_cnt <= (mem_req_i && !mem_ack_o) ? wait_cnt + 4'h1 : 4'h0;
		end
	end
endmodule // amd_partner

`default_nettype wire

// *** testbench/tb_top.sv ***
// Purpose: Self-checking bench for the address mode decoder.
// Assumes: Registers fixed at A=9C B=35 X=1200 Y=3400 SP=5600.
// Notes:   Inputs move on the falling edge only.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	logic                 clk_i = 1'b0;
	logic                 rst_n_i = 1'b0;
	logic                 fq_valid_i = 1'b0;
	logic [7:0]           fq_byte_i = 8'h00;
	logic [15:0]          insn_pc_i = 16'h0000;
	logic [3:0]           delay = 4'h0;
	logic                 fq_ready_o, attr_page2_o, attr_query_o, mem_req_o, mem_ack_i, res_valid_o;
	logic [7:0]           attr_opcode_o, mem_data_i;
	logic [15:0]          mem_addr_o;
	amd_pkg::amd_mode_t   attr_mode_i;
	amd_pkg::amd_regs_t   regs_i = {8'h9C, 8'h35, 16'h1200, 16'h3400, 16'h5600};
	amd_pkg::amd_result_t res_o, r;
	int                   n_errors = 0;
	int                   check_count = 0;

	always #2 clk_i = ~clk_i;

	amd_decoder dut_u (.clk_i, .rst_n_i, .fq_valid_i, .fq_byte_i, .insn_pc_i, .fq_ready_o, .attr_opcode_o,
		.attr_page2_o, .attr_query_o, .attr_mode_i, .regs_i, .mem_req_o, .mem_addr_o, .mem_ack_i,
		.mem_data_i, .res_valid_o, .res_o);
	amd_partner partner_u (.clk_i, .attr_opcode_i(attr_opcode_o), .attr_mode_o(attr_mode_i), .delay_i(delay),
		.mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i), .mem_data_o(mem_data_i));

	// ----
	// Shared tasks
	// ----
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic give_up();
		n_errors++;
		$display("unexpected wait overrun at %0t: got %h expected %h", $time, 1'b0, 1'b1);
		tally_and_finish();
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Bytes are packed first byte highest; the result lands in r.
	task automatic run(input logic [31:0] bytes, input int n, input logic [15:0] pc);
		int i;
		int k;
		insn_pc_i = pc;
		fq_valid_i = 1'b1;
		for (i = 0; i < n; i++) begin
			fq_byte_i = bytes[31-8*i -: 8];
			for (k = 0; k < 20 && fq_ready_o !== 1'b1; k++)
				@(negedge clk_i);
			if (k == 20)
				give_up();
			@(negedge clk_i);
		end
		fq_valid_i = 1'b0;
		for (k = 0; k < 60 && res_valid_o !== 1'b1; k++)
			@(negedge clk_i);
		if (k == 60)
			give_up();
		r = res_o;
		@(negedge clk_i);
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_modes();
		run(32'h4000_0000, 1, 16'h0100);
		chk(r.next_pc, 16'h0101);
		run(32'h417E_0000, 2, 16'h0FFF);
		chk(r.literal, 16'h007E);
		chk(r.next_pc, 16'h1001);
		run(32'h42AB_CD00, 3, 16'h2001);
		chk(r.literal, 16'hABCD);
		chk(r.mode, amd_pkg::LITERAL16_OPERAND_MODE);
		run(32'h43F1_0000, 2, 16'h0100);
		chk(r.address, 16'h00F1);
		run(32'h4412_3400, 3, 16'h0FFF);
		chk(r.address, 16'h1234);
		run(32'h45F0_0000, 2, 16'h0200);
		chk(r.address, 16'h01F2);
		run(32'h4601_0000, 3, 16'h0300);
		chk(r.address, 16'h0403);
		run(32'h1844_0010, 4, 16'h0400);
		chk({r.page2, r.opcode}, 16'h0144);
		chk(r.address, 16'h0010);
		run(32'h1818_0000, 2, 16'h0500);
		chk({r.page2, r.opcode}, 16'h0118);
		chk(r.next_pc, 16'h0502);
		$display("modes done");
	endtask

	task automatic t_const();
		run(32'h4710_0000, 2, 16'h0600);
		chk(r.address, 16'h11F0);
		chk(r.form, amd_pkg::INDEXED_SHORT_MODE);
		run(32'h47CF_0000, 2, 16'h0400);
		chk(r.address, 16'h0411);
		run(32'h47E9_8000, 3, 16'h0600);
		chk(r.address, 16'h3380);
		chk(r.form, amd_pkg::INDEXED_NINE_BIT_MODE);
		run(32'h47F8_1000, 3, 16'h0700);
		chk(r.address, 16'h0713);
		run(32'h47F2_8000, 4, 16'h0600);
		chk(r.address, 16'hD600);
		chk(r.form, amd_pkg::INDEXED_SIXTEEN_BIT_MODE);
		$display("constant offsets done");
	endtask

	task automatic t_auto();
		run(32'h4728_0000, 2, 16'h0800);
		chk(r.address, 16'h11F8);
		chk({r.wb_en, r.wb_sel, r.wb_value[12:0]}, {1'b1, 2'h0, 13'h11F8});
		chk(r.wb_value, 16'h11F8);
		run(32'h47B7_0000, 2, 16'h0800);
		chk(r.address, 16'h5600);
		chk({r.wb_en, r.wb_sel, r.wb_value[12:0]}, {1'b1, 2'h2, 13'h1608});
		chk(r.wb_value, 16'h5608);
		run(32'h4778_0000, 2, 16'h0800);
		chk(r.wb_value, 16'h33F8);
		run(32'h4760_0000, 2, 16'h0800);
		chk(r.address, 16'h3401);
		run(32'h47F0_0500, 3, 16'h0800);
		chk({15'h0000, r.wb_en}, 16'h0000);
		chk(r.address, 16'h5605);
		$display("auto adjust done");
	endtask

	task automatic t_acc();
		run(32'h47E4_0000, 2, 16'h0900);
		chk(r.address, 16'h129C);
		run(32'h47E5_0000, 2, 16'h0900);
		chk(r.address, 16'h1235);
		run(32'h47FE_0000, 2, 16'h0500);
		chk(r.address, 16'hA137);
		chk(r.form, amd_pkg::INDEXED_ACCUMULATOR_MODE);
		$display("accumulator offsets done");
	endtask

	task automatic t_indirect();
		delay = 4'h3;
		run(32'h47E3_0100, 4, 16'h0A00);
		chk(r.address, 16'hA5A4);
		chk(r.form, amd_pkg::INDEXED_SIXTEEN_INDIRECT_MODE);
		delay = 4'h0;
		run(32'h47F7_0000, 2, 16'h0A00);
		chk(r.address, 16'h9093);
		chk({15'h0000, r.indirect}, 16'h0001);
		$display("indirect done");
	endtask

	initial begin
		repeat (6) @(negedge clk_i);
		rst_n_i = 1'b1;
		t_modes();
		t_const();
		t_auto();
		t_acc();
		t_indirect();
		tally_and_finish();
	end
endmodule // tb_top

`default_nettype wire
